// ==== core/fuel_gauge_param_regs.v ====
// Fuel gauge parameter and readout register bank
`timescale 1ns/10ps
`include "fuel_gauge_param_regs.vh"

module fuel_gauge_param_regs #(
   parameter RES_COUNT = 6
) (
   // Clock and reset
   input  wire        sys_clk_in,
   input  wire        nrst_in,
   // Register port from serial front end
   input  wire [7:0]  reg_addr_in,
   input  wire [7:0]  reg_wdata_in,
   input  wire        reg_wr_in,
   input  wire        reg_rd_in,
   output reg  [7:0]  reg_rdata_out,
   // Temperature from thermistor measurement
   input  wire [5:0]  thermistor_input_in,
   // Results from the estimator
   input  wire        soc_valid_in,
   input  wire [7:0]  soc_value_in,
   input  wire        vbat_valid_in,
   input  wire [12:0] vbat_mv_in,
   // Resistance table to the estimator
   output wire [7:0]  bat_resistance_0c_out,
   output wire [7:0]  bat_resistance_10c_out,
   output wire [7:0]  bat_resistance_20c_out,
   output wire [7:0]  bat_resistance_30c_out,
   output wire [7:0]  bat_resistance_40c_out,
   output wire [7:0]  bat_resistance_60c_out,
   // Coefficients and temperature to the estimator
   output reg  [1:0]  low_charge_resistance_scale_out,
   output reg  [3:0]  charging_resistance_coefficient_out,
   output reg         temperature_source_select_out,
   output reg  [5:0]  host_battery_temperature_out,
   output reg  [5:0]  battery_temperature_out,
   output reg         soc_clear_out
);

   // ****************************************
   // Write decode
   // ****************************************
   wire [7:0]  res_q [0:RES_COUNT-1];
   wire [6:0]  soc_q;
   wire [12:0] vbat_q;
   wire        wr_coef;
   wire        wr_temp;
   wire        clear_req;
   reg  [6:0]  soc_clamped;

   assign wr_coef   = reg_wr_in && (reg_addr_in == `ADDR_RES_COEF);
   assign wr_temp   = reg_wr_in && (reg_addr_in == `ADDR_TEMP_CFG);
   assign clear_req = reg_wr_in && (reg_addr_in == `ADDR_SOC_CLEAR)
                      && reg_wdata_in[`SOC_CLEAR_BIT];

   // ****************************************
   // Temperature-indexed resistance table
   // ****************************************
   genvar i;
   generate
      for (i = 0; i < RES_COUNT; i = i + 1) begin : g_res
         localparam integer ADDR_I = `ADDR_RES_0C + i;
         localparam [7:0] ADDR = ADDR_I[7:0];  // Offset kept to bus width
         reg [7:0] val_q;
         // One byte per temperature point, 32 mohm per step
         always @(posedge sys_clk_in) begin
            if (!nrst_in) begin
               val_q <= `RST_RES;
            end else if (reg_wr_in && (reg_addr_in == ADDR)) begin
               val_q <= reg_wdata_in;
            end
         end
         assign res_q[i] = val_q;
      end
   endgenerate

   assign bat_resistance_0c_out  = res_q[0];
   assign bat_resistance_10c_out = res_q[1];
   assign bat_resistance_20c_out = res_q[2];
   assign bat_resistance_30c_out = res_q[3];
   assign bat_resistance_40c_out = res_q[4];
   assign bat_resistance_60c_out = res_q[5];

   // ****************************************
   // Coefficient and temperature configuration
   // ****************************************
   // Only defined fields are stored; bits 7:6 and 7 dropped
   always @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         low_charge_resistance_scale_out     <= `RST_LOW_SCALE;
         charging_resistance_coefficient_out <= `RST_CHG_COEF;
         temperature_source_select_out       <= `RST_TEMP_SRC;
         host_battery_temperature_out        <= `RST_HOST_TEMP;
      end else begin
         if (wr_coef) begin
            low_charge_resistance_scale_out <=
               reg_wdata_in[`LOW_SCALE_MSB:`LOW_SCALE_LSB];
            charging_resistance_coefficient_out <=
               reg_wdata_in[`CHG_COEF_MSB:`CHG_COEF_LSB];
         end
         if (wr_temp) begin
            temperature_source_select_out <= reg_wdata_in[`TEMP_SRC_BIT];
            host_battery_temperature_out  <=
               reg_wdata_in[`HOST_TEMP_MSB:`HOST_TEMP_LSB];
         end
      end
   end

   // Temperature handed to the gauge, per source select
   always @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         battery_temperature_out <= 6'h00;
      end else if (temperature_source_select_out) begin
         battery_temperature_out <= host_battery_temperature_out;
      end else begin
         battery_temperature_out <= thermistor_input_in;
      end
   end

   // ****************************************
   // Results
   // ****************************************
   // Limit estimator SOC to 100 percent
   always @* begin
      if (soc_value_in > {1'b0, `SOC_MAX}) begin
         soc_clamped = `SOC_MAX;
      end else begin
         soc_clamped = soc_value_in[`SOC_MSB:0];
      end
   end

   result_hold #(
      .WIDTH (7)
   ) u_soc_hold (
      .sys_clk_in (sys_clk_in),
      .nrst_in    (nrst_in),
      .load_in    (soc_valid_in),
      .clear_in   (clear_req),
      .data_in    (soc_clamped),
      .value_out  (soc_q)
   );

   result_hold #(
      .WIDTH (13)
   ) u_vbat_hold (
      .sys_clk_in (sys_clk_in),
      .nrst_in    (nrst_in),
      .load_in    (vbat_valid_in),
      .clear_in   (clear_req),
      .data_in    (vbat_mv_in),
      .value_out  (vbat_q)
   );

   // Clear pulse to the estimator
   always @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         soc_clear_out <= 1'b0;
      end else begin
         soc_clear_out <= clear_req;
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   // Registered read data, zero for unused bits and addresses
   always @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            `ADDR_RES_0C:     reg_rdata_out <= res_q[0];
            `ADDR_RES_10C:    reg_rdata_out <= res_q[1];
            `ADDR_RES_20C:    reg_rdata_out <= res_q[2];
            `ADDR_RES_30C:    reg_rdata_out <= res_q[3];
            `ADDR_RES_40C:    reg_rdata_out <= res_q[4];
            `ADDR_RES_60C:    reg_rdata_out <= res_q[5];
            `ADDR_RES_COEF:   reg_rdata_out <= {2'b00, low_charge_resistance_scale_out,
                                                charging_resistance_coefficient_out};
            `ADDR_TEMP_CFG:   reg_rdata_out <= {1'b0, temperature_source_select_out,
                                                host_battery_temperature_out};
            `ADDR_SOC_RESULT: reg_rdata_out <= {1'b0, soc_q};
            `ADDR_VBAT_HIGH:  reg_rdata_out <= vbat_q[12:`VBAT_HIGH_LSB];
            `ADDR_VBAT_LOW:   reg_rdata_out <= {vbat_q[4:0], 3'b000};
            default:          reg_rdata_out <= 8'h00;
         endcase
      end
   end

endmodule // fuel_gauge_param_regs

// ==== include/fuel_gauge_param_regs.vh ====
// Register map constants for the fuel gauge parameter register bank
// Overview of operation
// - 0x19 holds 0C resistance, reset 0x3f
// - 0x1a holds 10C resistance, 2016 mohm
// - 0x1b..0x1e hold 20-60C resistances
// - Bits 5:4 scale low-charge resistance 1/2/4/8x
// - Bits 3:0 charging coefficient, reset 1000
// - Bit 6 picks thermistor or host temperature
// - Bits 5:0 host temperature, reset 11011
// - 0x21 reports SOC percent, clamped 0-100
// - 0x22 holds battery voltage bits 12:5
// - 0x23 bits 7:3 hold voltage bits 4:0
// - Writing 0x25 bit 7 clears results
`ifndef FUEL_GAUGE_PARAM_REGS_VH
`define FUEL_GAUGE_PARAM_REGS_VH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_RES_0C        8'h19
`define ADDR_RES_10C       8'h1a
`define ADDR_RES_20C       8'h1b
`define ADDR_RES_30C       8'h1c
`define ADDR_RES_40C       8'h1d
`define ADDR_RES_60C       8'h1e
`define ADDR_RES_COEF      8'h1f
`define ADDR_TEMP_CFG      8'h20
`define ADDR_SOC_RESULT    8'h21
`define ADDR_VBAT_HIGH     8'h22
`define ADDR_VBAT_LOW      8'h23
`define ADDR_SOC_CLEAR     8'h25

// ****************************************
// Field positions
// ****************************************
`define LOW_SCALE_MSB      5
`define LOW_SCALE_LSB      4
`define CHG_COEF_MSB       3
`define CHG_COEF_LSB       0
`define TEMP_SRC_BIT       6
`define HOST_TEMP_MSB      5
`define HOST_TEMP_LSB      0
`define SOC_MSB            6
`define SOC_CLEAR_BIT      7
`define VBAT_HIGH_LSB      5
`define VBAT_LOW_POS       3

// ****************************************
// Reset values and limits
// ****************************************
`define RST_RES            8'h3f
`define RST_LOW_SCALE      2'h0
`define RST_CHG_COEF       4'h8
`define RST_TEMP_SRC       1'b0
`define RST_HOST_TEMP      6'h1b
`define SOC_MAX            7'h64

`endif

// ==== core/result_hold.v ====
// Result holding register with load and clear
`timescale 1ns/10ps

module result_hold #(
   parameter WIDTH = 8
) (
   // Clock and reset
   input  wire             sys_clk_in,
   input  wire             nrst_in,
   // Control
   input  wire             load_in,
   input  wire             clear_in,
   input  wire [WIDTH-1:0] data_in,
   // Held value
   output reg  [WIDTH-1:0] value_out
);

   // New result wins over a clear in the same cycle
   always @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         value_out <= {WIDTH{1'b0}};
      end else if (load_in) begin
         value_out <= data_in;
      end else if (clear_in) begin
         value_out <= {WIDTH{1'b0}};
      end
   end

endmodule // result_hold

// ==== verification/param_regs_properties.sv ====
// Concurrent checks on the register bank ports
`timescale 1ns/10ps
module param_regs_props (
   // Clock and reset
   input wire       sys_clk_in,
   input wire       nrst_in,
   // Register port
   input wire [7:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire       reg_wr_in,
   input wire       reg_rd_in,
   input wire [7:0] reg_rdata_out,
   // Estimator side
   input wire [5:0] thermistor_input_in,
   input wire [7:0] bat_resistance_0c_out,
   input wire [1:0] low_charge_resistance_scale_out,
   input wire [3:0] charging_resistance_coefficient_out,
   input wire       temperature_source_select_out,
   input wire [5:0] host_battery_temperature_out,
   input wire [5:0] battery_temperature_out,
   input wire       soc_clear_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!nrst_in);
   // ****************************************
   // Request shapes
   // ****************************************
   sequence s_wr(ad); reg_wr_in && reg_addr_in == ad; endsequence
   sequence s_clr; s_wr(8'h25) ##0 reg_wdata_in[7]; endsequence
   property p_res0; s_wr(8'h19) |=> bat_resistance_0c_out == $past(reg_wdata_in); endproperty
   a_res0: assert property (p_res0) else $error("bad 0c write");
   property p_coef; s_wr(8'h1f) |=> {low_charge_resistance_scale_out,
      charging_resistance_coefficient_out} == $past(reg_wdata_in[5:0]); endproperty
   a_coef: assert property (p_coef) else $error("bad coef write");
   property p_tcfg; s_wr(8'h20) |=> {temperature_source_select_out,
      host_battery_temperature_out} == $past(reg_wdata_in[6:0]); endproperty
   a_tcfg: assert property (p_tcfg) else $error("bad temp write");
   property p_tsel; $past(nrst_in) |-> battery_temperature_out == ($past(
      temperature_source_select_out) ? $past(host_battery_temperature_out) :
      $past(thermistor_input_in)); endproperty
   a_tsel: assert property (p_tsel) else $error("bad temp source");
   property p_clr; s_clr |=> soc_clear_out ##1 !soc_clear_out; endproperty
   a_clr: assert property (p_clr) else $error("no clear pulse");
   property p_clrsrc; soc_clear_out |-> $past(reg_wr_in && reg_addr_in == 8'h25
      && reg_wdata_in[7]); endproperty
   a_clrsrc: assert property (p_clrsrc) else $error("stray clear");
   property p_unmap; reg_rd_in && reg_addr_in > 8'h25 |=> reg_rdata_out == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped nonzero");
   property p_soc; reg_rd_in && reg_addr_in == 8'h21 |=> reg_rdata_out <= 8'h64; endproperty
   a_soc: assert property (p_soc) else $error("soc out of range");
endmodule // param_regs_props
bind fuel_gauge_param_regs param_regs_props chk (
   .sys_clk_in                          (sys_clk_in),
   .nrst_in                             (nrst_in),
   .reg_addr_in                         (reg_addr_in),
   .reg_wdata_in                        (reg_wdata_in),
   .reg_wr_in                           (reg_wr_in),
   .reg_rd_in                           (reg_rd_in),
   .reg_rdata_out                       (reg_rdata_out),
   .thermistor_input_in                 (thermistor_input_in),
   .bat_resistance_0c_out               (bat_resistance_0c_out),
   .low_charge_resistance_scale_out     (low_charge_resistance_scale_out),
   .charging_resistance_coefficient_out (charging_resistance_coefficient_out),
   .temperature_source_select_out       (temperature_source_select_out),
   .host_battery_temperature_out        (host_battery_temperature_out),
   .battery_temperature_out             (battery_temperature_out),
   .soc_clear_out                       (soc_clear_out)
);

// ==== verification/host_port_model.sv ====
// Host register port driver model
`timescale 1ns/10ps
module host_port_model (
   // Clock
   input  wire       sys_clk_in,
   // Register port
   output reg  [7:0] addr_out,
   output reg  [7:0] wdata_out,
   output reg        wr_out,
   output reg        rd_out,
   input  wire [7:0] rdata_in
);
   initial {addr_out, wdata_out, wr_out, rd_out} = 18'h0;
   // One request; the idle bus then shows inverted address and data, strobes low
   task xfer(input [7:0] ad, input [7:0] dt, input w, output [7:0] q);
      begin
         @(posedge sys_clk_in) #1;
         {addr_out, wdata_out, wr_out, rd_out} = {ad, dt, w, !w};
         @(posedge sys_clk_in) #1;
         q = rdata_in;
         {addr_out, wdata_out, wr_out, rd_out} = {~ad, ~dt, 2'b00};
      end
   endtask
endmodule // host_port_model

// ==== verification/tb_top.sv ====
// Self-checking testbench for the fuel gauge register bank
`timescale 1ns/10ps
module tb_top;
   reg         clk = 1'b0;
   reg         nrst = 1'b0;
   reg         up = 1'b0;
   reg  [7:0]  s = 8'h00;
   reg  [5:0]  th = 6'h2a;
   wire [7:0]  a, w, q, r0, r1, r2, r3, r4, r5;
   wire [5:0]  bt;
   wire [1:0]  sc;
   wire        wr, rd, clr;
   integer     mismatches = 0;
   integer     n_tests = 0;
   integer     i;
   reg  [7:0]  d;
   // Clock
   always #25 clk = ~clk;
   host_port_model m (.sys_clk_in(clk), .addr_out(a), .wdata_out(w), .wr_out(wr),
      .rd_out(rd), .rdata_in(q));
   fuel_gauge_param_regs dut (.sys_clk_in(clk), .nrst_in(nrst), .reg_addr_in(a),
      .reg_wdata_in(w), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(q),
      .thermistor_input_in(th), .soc_valid_in(up), .soc_value_in(s), .vbat_valid_in(up),
      .vbat_mv_in(13'h1abc), .bat_resistance_0c_out(r0), .bat_resistance_10c_out(r1),
      .bat_resistance_20c_out(r2), .bat_resistance_30c_out(r3), .bat_resistance_40c_out(r4),
      .bat_resistance_60c_out(r5), .low_charge_resistance_scale_out(sc),
      .charging_resistance_coefficient_out(), .temperature_source_select_out(),
      .host_battery_temperature_out(), .battery_temperature_out(bt), .soc_clear_out(clr));
   task chk(input [7:0] e, input [7:0] g);
      begin
         n_tests = n_tests + 1;
         if (g !== e) begin
            mismatches = mismatches + 1;
            $display("[ERR] %0t exp %h got %h", $time, e, g);
         end
      end
   endtask
   task wr8(input [7:0] ad, input [7:0] dt);
      m.xfer(ad, dt, 1'b1, d);
   endtask
   task rchk(input [7:0] ad, input [7:0] e);
      begin
         m.xfer(ad, 8'h00, 1'b0, d);
         chk(e, d);
      end
   endtask
   // Estimator result update pulse
   task upd(input [7:0] v);
      begin
         @(posedge clk) #1;
         {s, up} = {v, 1'b1};
         @(posedge clk) #1;
         up = 1'b0;
      end
   endtask
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", n_tests, mismatches);
         if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
         else $display("Testbench failed");
         $finish;
      end
   endtask
   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      #1 nrst = 1'b1;
      for (i = 8'h19; i < 8'h1f; i = i + 1) rchk(i, 8'h3f);
      rchk(8'h1f, 8'h08);
      rchk(8'h20, 8'h1b);
      for (i = 8'h21; i < 8'h24; i = i + 1) rchk(i, 8'h00);
      for (i = 8'h19; i < 8'h1f; i = i + 1) begin
         wr8(i, i ^ 8'ha5);
         rchk(i, i ^ 8'ha5);
      end
      chk(8'hbc, r0);
      chk(8'hbf, r1);
      chk(8'hbe, r2);
      chk(8'hb9, r3);
      chk(8'hb8, r4);
      chk(8'hbb, r5);
      for (i = 0; i < 4; i = i + 1) begin
         wr8(8'h1f, 8'hc3 | (i << 4));
         rchk(8'h1f, 8'h03 | (i << 4));
         chk(i, {6'h0, sc});
      end
      wr8(8'h20, 8'h85);
      rchk(8'h20, 8'h05);
      repeat (2) @(posedge clk);
      #1 chk(8'h2a, {2'b0, bt});
      wr8(8'h20, 8'h7f);
      repeat (2) @(posedge clk);
      #1 chk(8'h3f, {2'b0, bt});
      th = 6'h15;
      repeat (2) @(posedge clk);
      #1 chk(8'h3f, {2'b0, bt});
      wr8(8'h20, 8'h05);
      repeat (2) @(posedge clk);
      #1 chk(8'h15, {2'b0, bt});
      upd(8'd120);
      rchk(8'h21, 8'h64);
      rchk(8'h22, 8'hd5);
      rchk(8'h23, 8'he0);
      wr8(8'h21, 8'h11);
      rchk(8'h21, 8'h64);
      rchk(8'h30, 8'h00);
      upd(8'd37);
      rchk(8'h21, 8'h25);
      wr8(8'h25, 8'h80);
      chk(8'h01, {7'h0, clr});
      for (i = 8'h21; i < 8'h24; i = i + 1) rchk(i, 8'h00);
      complete_run;
   end
endmodule // tb_top
